// >>> design/paged_status_readout.sv
// Paged status readout register bank on an AHB-Lite slave.
// Assumes one AHB-Lite master, single word transfers, analog status inputs
// synchronous to hclk.
// Function
// - Gain steps 0 to 4 are valid at 3 dB each; codes 5 to 7 show no gain.
// - Gain page 01 shows the VCO range selection result in bits 7:4.
// - Gain page 10 shows the high-pass trim in 7:4 and low-pass in 3:0.
// - Converter page 00 shows the conversion result of the chosen source.
// - A conversion starts only on the trigger command; result after 20 us.
// - Converter page 01 bit 7 shows the reference oscillator type.
// - Converter page 01 bits 6:3 read as zero.
// - Converter page 01 bits 2:0 show the supply level code in use.
// - Page bits 7:6 select the converter page and 5:4 the gain page.
// - A finished conversion sets the done flag bit 3 and raises an irq when the irq mask bit 3 is set.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module paged_status_readout (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Analog status inputs
   input  wire logic [2:0]  gain_step_q,
   input  wire logic [2:0]  gain_step_i,
   input  wire logic [3:0]  vco_range_info,
   input  wire logic [2:0]  vco_pin_level,
   input  wire logic [3:0]  highpass_trim,
   input  wire logic [3:0]  lowpass_trim,
   input  wire logic        osc_grounded,
   input  wire logic [2:0]  supply_level_code,
   input  wire logic [7:0]  mixer_dc_level,
   input  wire logic [7:0]  ext_conv_pin_level,
   // Control outputs
   output logic             meas_source_ext,
   output logic             irq
);
   // ***********************************************************************
   // Bus address phase capture
   // ***********************************************************************
   logic        dp_valid_r;
   logic        dp_write_r;
   logic [9:0]  dp_addr_r;
   logic [7:0]  page_sel_r;
   logic [7:0]  cmd_status_r;
   logic        irq_status_r;
   logic        irq_mask_r;
   logic        conv_start_r;
   logic        conv_done;
   logic        conv_busy;
   logic [7:0]  conv_result;
   logic [7:0]  read_mux;
   logic [1:0]  gain_page;
   logic [1:0]  conv_page;
   logic        wr_en;
   logic        unused_bits;

   assign unused_bits = ^{haddr[31:10], haddr[1:0], hsize, htrans[0],
                          hwdata[31:8]};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r  <= '0;
      end else if (hready) begin
         dp_valid_r <= hsel && htrans[1];
         dp_write_r <= hwrite;
         dp_addr_r  <= haddr[9:0];
      end
   end

   assign wr_en = dp_valid_r && dp_write_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ***********************************************************************
   // Writable control registers
   // ***********************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         page_sel_r <= status_readout_pkg::PAGE_SEL_RESET;
      end else if (wr_en && dp_addr_r == status_readout_pkg::ADDR_PAGE_SEL) begin
         page_sel_r <= hwdata[7:0];
      end
   end

   assign conv_page = page_sel_r[status_readout_pkg::CONV_PAGE_LSB +: 2];
   assign gain_page = page_sel_r[status_readout_pkg::GAIN_PAGE_LSB +: 2];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meas_source_ext <= 1'b0;
      end else if (wr_en && dp_addr_r == status_readout_pkg::ADDR_CONTROL) begin
         meas_source_ext <= hwdata[0];
      end
   end

   // The trigger command is written as a byte to the command/status register's
   // command lane; any other code leaves the converter idle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_start_r <= 1'b0;
      end else begin
         conv_start_r <= wr_en &&
            dp_addr_r == status_readout_pkg::ADDR_CMD_STATUS &&
            hwdata[7:0] == status_readout_pkg::CMD_TRIGGER_CONV;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_r <= 1'b0;
      end else if (wr_en && dp_addr_r == status_readout_pkg::ADDR_IRQ_MASK) begin
         irq_mask_r <= hwdata[status_readout_pkg::CONV_DONE_BIT];
      end
   end

   // ***********************************************************************
   // Conversion engine and completion flags
   // ***********************************************************************
   conv_sequencer u_conv (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .start     (conv_start_r),
      .sample_in (meas_source_ext ? ext_conv_pin_level : mixer_dc_level),
      .result    (conv_result),
      .done      (conv_done),
      .busy      (conv_busy)
   );

   // Done flag stays set until the next trigger starts a new conversion.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_status_r <= status_readout_pkg::ZERO_BYTE;
      end else if (conv_done) begin
         cmd_status_r[status_readout_pkg::CONV_DONE_BIT] <= 1'b1;
      end else if (conv_start_r) begin
         cmd_status_r[status_readout_pkg::CONV_DONE_BIT] <= 1'b0;
      end
   end

   // Set wins over a write-one clear in the same cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_r <= 1'b0;
      end else if (conv_done) begin
         irq_status_r <= 1'b1;
      end else if (wr_en && dp_addr_r == status_readout_pkg::ADDR_IRQ_STATUS &&
                   hwdata[status_readout_pkg::CONV_DONE_BIT]) begin
         irq_status_r <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= (irq_status_r || conv_done) && irq_mask_r;
      end
   end

   // ***********************************************************************
   // Paged read multiplexer
   // ***********************************************************************
   always_comb begin
      read_mux = status_readout_pkg::ZERO_BYTE;
      unique case (haddr[9:0])
         status_readout_pkg::ADDR_PAGE_SEL: begin
            read_mux = page_sel_r;
         end
         status_readout_pkg::ADDR_GAIN_VCO: begin
            if (gain_page == status_readout_pkg::PAGE_0) begin
               read_mux = {2'b00, gain_step_q, gain_step_i};
            end else if (gain_page == status_readout_pkg::PAGE_1) begin
               read_mux = {vco_range_info, 1'b1, vco_pin_level};
            end else if (gain_page == status_readout_pkg::PAGE_2) begin
               read_mux = {highpass_trim, lowpass_trim};
            end else begin
               read_mux = status_readout_pkg::ZERO_BYTE;
            end
         end
         status_readout_pkg::ADDR_CONVERTER: begin
            if (conv_page == status_readout_pkg::PAGE_0) begin
               read_mux = conv_result;
            end else if (conv_page == status_readout_pkg::PAGE_1) begin
               read_mux = {osc_grounded, 4'h0, supply_level_code};
            end else begin
               read_mux = status_readout_pkg::ZERO_BYTE;
            end
         end
         status_readout_pkg::ADDR_CMD_STATUS: begin
            read_mux = cmd_status_r;
         end
         status_readout_pkg::ADDR_CONTROL: begin
            read_mux = {6'h00, conv_busy, meas_source_ext};
         end
         status_readout_pkg::ADDR_IRQ_STATUS: begin
            read_mux = {4'h0, irq_status_r, 3'h0};
         end
         status_readout_pkg::ADDR_IRQ_MASK: begin
            read_mux = {4'h0, irq_mask_r, 3'h0};
         end
         default: begin
            read_mux = status_readout_pkg::ZERO_BYTE;
         end
      endcase
   end

   // Read data is captured at the address phase so it stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= {24'h00_0000, read_mux ^ {7'h00, 1'b0 & unused_bits}};
      end
   end
endmodule // paged_status_readout
`default_nettype wire

// >>> design/status_readout_pkg.sv
// Package with register offsets, field layouts and timing for the status readout.
// Assumes a 10 MHz hclk and an AHB-Lite master doing single word transfers.
package status_readout_pkg;
   // ***********************************************************************
   // Register byte addresses (printed index times four)
   // ***********************************************************************
   localparam logic [7:0] IDX_PAGE_SEL   = 8'h29;
   localparam logic [7:0] IDX_GAIN_VCO   = 8'h2c;
   localparam logic [7:0] IDX_CONVERTER  = 8'h2d;
   localparam logic [7:0] IDX_CMD_STATUS = 8'h2e;
   localparam logic [7:0] IDX_CONTROL    = 8'h30;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h32;
   localparam logic [9:0] ADDR_PAGE_SEL   = {IDX_PAGE_SEL, 2'b00};
   localparam logic [9:0] ADDR_GAIN_VCO   = {IDX_GAIN_VCO, 2'b00};
   localparam logic [9:0] ADDR_CONVERTER  = {IDX_CONVERTER, 2'b00};
   localparam logic [9:0] ADDR_CMD_STATUS = {IDX_CMD_STATUS, 2'b00};
   localparam logic [9:0] ADDR_CONTROL    = {IDX_CONTROL, 2'b00};
   localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [9:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};
   // ***********************************************************************
   // Field layouts and codes
   // ***********************************************************************
   localparam int          CONV_PAGE_LSB   = 6;
   localparam int          GAIN_PAGE_LSB   = 4;
   localparam logic [1:0]  PAGE_0          = 2'h0;
   localparam logic [1:0]  PAGE_1          = 2'h1;
   localparam logic [1:0]  PAGE_2          = 2'h2;
   localparam int          CONV_DONE_BIT   = 3;
   localparam logic [7:0]  CMD_TRIGGER_CONV = 8'h87;
   localparam logic [2:0]  GAIN_STEP_MAX   = 3'h4;
   localparam logic [7:0]  PAGE_SEL_RESET  = 8'h00;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   // ***********************************************************************
   // Timing
   // ***********************************************************************
   localparam int CLK_MHZ         = 10;
   localparam int CONV_TIME_US    = 20;
   localparam int CONV_CYCLES     = CONV_TIME_US * CLK_MHZ;
   localparam int CONV_CNT_W      = 8;
endpackage

// >>> design/conv_sequencer.sv
// Conversion sequencer: waits the conversion time after a trigger, then
// latches the sampled converter input and pulses done.
// Assumes the converter input is synchronous to hclk.
`timescale 1ns/10ps
`default_nettype none
module conv_sequencer (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Control
   input  wire logic       start,
   input  wire logic [7:0] sample_in,
   // Results
   output logic [7:0]      result,
   output logic            done,
   output logic            busy
);
   localparam logic [status_readout_pkg::CONV_CNT_W-1:0] LAST =
      status_readout_pkg::CONV_CNT_W'(status_readout_pkg::CONV_CYCLES - 1);

   logic [status_readout_pkg::CONV_CNT_W-1:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy  <= 1'b1;
            cnt_r <= '0;
         end else if (busy) begin
            if (cnt_r == LAST) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result <= status_readout_pkg::ZERO_BYTE;
      end else if (busy && cnt_r == LAST) begin
         result <= sample_in;
      end
   end
endmodule // conv_sequencer
`default_nettype wire

// >>> tb/paged_status_readout_sva.sv
// Checker for the paged status readout, bound to its top module.
// Assumes zero wait states and single word transfers.
`timescale 1ns/10ps
`default_nettype none
module paged_status_readout_sva (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Status and control
   input wire logic [2:0]  gain_step_q,
   input wire logic [2:0]  gain_step_i,
   input wire logic [3:0]  vco_range_info,
   input wire logic [2:0]  vco_pin_level,
   input wire logic [3:0]  highpass_trim,
   input wire logic [3:0]  lowpass_trim,
   input wire logic        osc_grounded,
   input wire logic [2:0]  supply_level_code,
   input wire logic        meas_source_ext,
   input wire logic        irq
);
   localparam logic [9:0] G = status_readout_pkg::ADDR_GAIN_VCO;
   localparam logic [9:0] C = status_readout_pkg::ADDR_CONVERTER;
   logic       wph_r;
   logic [9:0] wad_r;
   logic [1:0] gpg_r;
   logic [1:0] cpg_r;
   logic [7:0] tcnt_r;
   logic       mwr_r;
   wire        wdat = hready && wph_r;
   // Shadows of the page fields and cycles since the last trigger.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wph_r <= 1'b0;
         wad_r <= 10'h0;
         {cpg_r, gpg_r} <= 4'h0;
         tcnt_r <= 8'hff;
         mwr_r <= 1'b0;
      end else begin
         mwr_r <= wdat && wad_r == status_readout_pkg::ADDR_IRQ_MASK;
         if (hready) begin
            wph_r <= hsel && htrans[1] && hwrite;
            wad_r <= haddr[9:0];
         end
         if (wdat && wad_r == status_readout_pkg::ADDR_PAGE_SEL)
            {cpg_r, gpg_r} <= hwdata[7:4];
         if (wdat && wad_r == status_readout_pkg::ADDR_CMD_STATUS &&
             hwdata[7:0] == 8'h87)
            tcnt_r <= 8'h00;
         else if (tcnt_r != 8'hff)
            tcnt_r <= tcnt_r + 8'h01;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd(logic [9:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr == {22'h0, a};
   endsequence
   a_gain_page0 : assert property (
      s_rd(G) ##0 gpg_r == 2'h0 |=> hrdata ==
      {26'h0, $past(gain_step_q), $past(gain_step_i)})
      else $error("gain page 0 read wrong");
   a_vco_page1 : assert property (
      s_rd(G) ##0 gpg_r == 2'h1 |=> hrdata ==
      {24'h0, $past(vco_range_info), 1'b1, $past(vco_pin_level)})
      else $error("vco page read wrong");
   a_trim_page2 : assert property (
      s_rd(G) ##0 gpg_r == 2'h2 |=> hrdata ==
      {24'h0, $past(highpass_trim), $past(lowpass_trim)})
      else $error("trim page read wrong");
   a_osc_supply : assert property (
      s_rd(C) ##0 cpg_r == 2'h1 |=> hrdata ==
      {24'h0, $past(osc_grounded), 4'h0, $past(supply_level_code)})
      else $error("oscillator page read wrong");
   a_undef_zero : assert property (
      (s_rd(G) ##0 gpg_r == 2'h3) or (s_rd(C) ##0 cpg_r[1])
      |=> hrdata == 32'h0)
      else $error("undefined page not zero");
   a_conv_time : assert property (
      $rose(irq) |-> $past(mwr_r) || (tcnt_r >= 8'hc7 && tcnt_r < 8'hfa))
      else $error("irq outside conversion window");
   a_meas_src : assert property (
      wdat && wad_r == status_readout_pkg::ADDR_CONTROL
      |=> meas_source_ext == $past(hwdata[0]))
      else $error("source select not taken");
   a_resp_okay : assert property (hreadyout && !hresp)
      else $error("response not ready okay");
endmodule // paged_status_readout_sva
`default_nettype wire

// >>> tb/tb_paged_status_readout.sv
// Testbench for the paged status readout.
// Assumes the design package is compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_paged_status_readout;
   localparam logic [9:0] P = status_readout_pkg::ADDR_PAGE_SEL;
   localparam logic [9:0] G = status_readout_pkg::ADDR_GAIN_VCO;
   localparam logic [9:0] C = status_readout_pkg::ADDR_CONVERTER;
   localparam logic [9:0] S = status_readout_pkg::ADDR_CMD_STATUS;
   localparam logic [9:0] K = status_readout_pkg::ADDR_CONTROL;
   localparam logic [9:0] I = status_readout_pkg::ADDR_IRQ_STATUS;
   localparam logic [9:0] M = status_readout_pkg::ADDR_IRQ_MASK;
   typedef struct packed {
      logic [7:0]  pg;
      logic [9:0]  a;
      logic [24:0] st;
      logic [7:0]  ex;
   } row_s;
   // Status word: q, i, range, pin, hp, lp, osc, supply.
   row_s rows [10] = '{
      '{8'h00, G, 25'h22b5c3e, 8'h05}, '{8'h10, G, 25'h22b5c3e, 8'h6d},
      '{8'h20, G, 25'h22b5c3e, 8'hc3}, '{8'h30, G, 25'h22b5c3e, 8'h00},
      '{8'h40, C, 25'h22b5c3e, 8'h86}, '{8'h80, C, 25'h22b5c3e, 8'h00},
      '{8'h00, G, 25'h02280f3, 8'h04}, '{8'h50, G, 25'h02280f3, 8'h58},
      '{8'h60, C, 25'h02280f3, 8'h03}, '{8'he0, G, 25'h02280f3, 8'h0f}};
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, osc_grounded;
   logic        hreadyout, hresp, meas_source_ext, irq;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0]  htrans;
   logic [2:0]  hsize, gain_step_q, gain_step_i, vco_pin_level;
   logic [2:0]  supply_level_code;
   logic [3:0]  vco_range_info, highpass_trim, lowpass_trim;
   logic [7:0]  mixer_dc_level, ext_conv_pin_level;
   wire         hready = hreadyout;
   int          err_total = 0;
   int          n_checks = 0;
   paged_status_readout DUT (.*);
   always #50 hclk = ~hclk;
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic bus(logic w, logic [9:0] a, logic [31:0] wd);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, a};
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1 && ++n < 99);
      d = hrdata;
      if (n >= 99)
         err_total++;
   endtask
   task automatic wr(logic [9:0] a, logic [7:0] v);
      bus(1'b1, a, {24'h0, v});
   endtask
   task automatic rd(logic [9:0] a, logic [7:0] ex, string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, {24'h0, ex}, d);
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic rst();
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic conv(logic [7:0] ex);
      int n;
      n = 0;
      wr(S, 8'h87);
      // The old done flag clears one edge after the trigger's data phase.
      @(posedge hclk);
      bus(1'b0, S, 32'h0);
      chk("done early", 32'h0, d & 32'h8);
      while (irq !== 1'b1 && n++ < 400) tick(1);
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b0, S, 32'h0);
      chk("done", 32'h8, d & 32'h8);
      rd(C, ex, "result");
   endtask
   initial begin
      repeat (5000) @(posedge hclk);
      err_total++;
      test_done();
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} <= '0;
      hsize <= 3'h2;
      {mixer_dc_level, ext_conv_pin_level} <= 16'h5aa5;
      {gain_step_q, gain_step_i, vco_range_info, vco_pin_level,
       highpass_trim, lowpass_trim, osc_grounded, supply_level_code} <= '0;
      rst();
      chk("reset out", 32'h0, {30'h0, irq, meas_source_ext});
      rd(P, 8'h00, "page reset");
      rd(10'h3fc, 8'h00, "unmapped");
      foreach (rows[k]) begin
         {gain_step_q, gain_step_i, vco_range_info, vco_pin_level,
          highpass_trim, lowpass_trim, osc_grounded,
          supply_level_code} <= rows[k].st;
         wr(P, rows[k].pg);
         rd(P, rows[k].pg, "page");
         rd(rows[k].a, rows[k].ex, "status");
      end
      wr(M, 8'h08);
      wr(P, 8'h00);
      tick(300);
      chk("no start", 32'h0, {31'h0, irq});
      conv(8'h5a);
      wr(M, 8'h00);
      tick(1);
      chk("masked", 32'h0, {31'h0, irq});
      wr(M, 8'h08);
      tick(1);
      chk("unmasked", 32'h1, {31'h0, irq});
      rd(I, 8'h08, "irq status");
      wr(I, 8'h08);
      tick(1);
      chk("cleared", 32'h0, {31'h0, irq});
      wr(K, 8'h01);
      tick(1);
      chk("ext src", 32'h1, {31'h0, meas_source_ext});
      conv(8'ha5);
      wr(P, 8'h50);
      rst();
      rd(P, 8'h00, "page rerst");
      test_done();
   end
endmodule // tb_paged_status_readout
bind paged_status_readout paged_status_readout_sva u_sva (.*);
`default_nettype wire
